// File: verilog/ptu_pkg.sv
// constants for the periodic tick unit: register map, field positions, tap ratios
// assumes a 32-bit AHB-Lite slave; one aligned word per register
package ptu_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;
  // control register fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_IE_BIT    = 1;
  localparam int CTRL_ACK_BIT   = 2;
  localparam int CTRL_RATE_LSB  = 4;
  localparam int CTRL_PREDIV_BIT = 8;
  localparam int CTRL_OSCSTOP_BIT = 9;
  // status register fields
  localparam int STAT_FLAG_BIT  = 0;
  localparam int STAT_STOP_BIT  = 8;
  localparam int STAT_WAIT_BIT  = 9;
  // chain geometry
  localparam int CHAIN_W        = 15;
  localparam int PREDIV_W       = 7;
  localparam logic [6:0] PREDIV_MAX = 7'h7f;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // htrans encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  typedef logic [3:0] ptu_tap_t;
  // chain bit index whose rising edge is the overflow for each rate code
  // ratios 32768,8192,2048,128,64,32,16,8 -> bits 14,12,10,6,5,4,3,2
  localparam ptu_tap_t TAP_0 = 4'he;
  localparam ptu_tap_t TAP_1 = 4'hc;
  localparam ptu_tap_t TAP_2 = 4'ha;
  localparam ptu_tap_t TAP_3 = 4'h6;
  localparam ptu_tap_t TAP_4 = 4'h5;
  localparam ptu_tap_t TAP_5 = 4'h4;
  localparam ptu_tap_t TAP_6 = 4'h3;
  localparam ptu_tap_t TAP_7 = 4'h2;
endpackage

// File: verilog/ptu_divider.sv
// divider chain of the periodic tick unit with optional divide-by-128 front stage
// assumes xclk_tick_in is a one-cycle pulse on clk_in, already synchronised
`timescale 1ns/1ps
module ptu_divider (
  input  wire logic       clk_in,        // system clock
  input  wire logic       rst_b_in,      // sync reset, active low
  input  wire logic       run_in,        // chain enabled; low clears it
  input  wire logic       xclk_tick_in,  // one pulse per crystal clock rising edge
  input  wire logic       prediv_in,     // insert divide-by-128
  input  wire logic [2:0] rate_in,       // tap select
  output logic            ovf_out,       // one-cycle overflow pulse
  output logic [14:0]     count_out      // chain value
);
  logic [14:0] chain_reg, chain_next;
  logic [6:0]  pre_reg, pre_next;
  logic        ovf_reg, ovf_next;
  logic        adv;
  ptu_pkg::ptu_tap_t tap;

  always_comb begin
    unique case (rate_in)
      3'h0: tap = ptu_pkg::TAP_0;
      3'h1: tap = ptu_pkg::TAP_1;
      3'h2: tap = ptu_pkg::TAP_2;
      3'h3: tap = ptu_pkg::TAP_3;
      3'h4: tap = ptu_pkg::TAP_4;
      3'h5: tap = ptu_pkg::TAP_5;
      3'h6: tap = ptu_pkg::TAP_6;
      3'h7: tap = ptu_pkg::TAP_7;
    endcase
  end

  always_comb begin
    pre_next   = pre_reg;
    chain_next = chain_reg;
    ovf_next   = 1'b0;
    adv        = 1'b0;
    if (!run_in) begin
      pre_next   = '0;              // [R3]
      chain_next = '0;              // [R3]
    end else if (xclk_tick_in) begin
      if (prediv_in) begin          // [R2]
        pre_next = pre_reg + 7'h01;
        adv      = (pre_reg == ptu_pkg::PREDIV_MAX);
      end else begin
        adv = 1'b1;                 // [R2]
      end
      if (adv) begin
        chain_next = chain_reg + 15'h0001;  // [R1]
        // the tap bit rises first after half its period from zero, then once a period [R7]
        ovf_next = ~chain_reg[tap] & chain_next[tap];  // [R4] [R8] [R9]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pre_reg   <= '0;
      chain_reg <= '0;
      ovf_reg   <= 1'b0;
    end else begin
      pre_reg   <= pre_next;
      chain_reg <= chain_next;
      ovf_reg   <= ovf_next;
    end
  end

  assign ovf_out   = ovf_reg;
  assign count_out = chain_reg;
endmodule

// File: verilog/ptu_top.sv
// periodic tick unit: AHB-Lite register slave, divider chain, event flag and interrupt
// assumes crystal_clock_out arrives asynchronously; stop and wait come from the core
// Function
// [R1] divider chain has fifteen stages, eight outputs selectable as overflow taps
// [R2] configuration option inserts divide-by-128 ahead of the chain
// [R3] counter held at zero while disabled, counts from zero once enabled
// [R4] event flag set on each overflow at the selected tap
// [R5] interrupt requested while flag set and interrupt enable set; the code also requires the mask register bit set
// [R6] writing one to acknowledge clears the flag; software acknowledges every event
// [R7] first event near half period after enabling, later ones at full period
// [R8] without predivide codes 0-7 divide by 32768,8192,2048,128,64,32,16,8
// [R9] with predivide codes 0-7 divide by 4194304 down to 1024
// [R10] software leaves the rate select alone while enabled
// [R11] keeps counting in stop when oscillator-run-in-stop is set
// [R12] idle in stop without that option; registers closed during stop
// [R13] keeps running in wait; registers closed during wait
// [R14] software should disable before wait when events not needed
// [R15] count clock derived from the crystal clock output
// [R16] overflow coinciding with acknowledge leaves the flag set
`timescale 1ns/1ps
module ptu_top (
  input  wire logic        clk_in,             // 100 MHz system clock
  input  wire logic        rst_b_in,           // sync reset, active low
  input  wire logic        hsel_in,            // ahb slave select
  input  wire logic [31:0] haddr_in,           // ahb address
  input  wire logic [1:0]  htrans_in,          // ahb transfer type
  input  wire logic        hwrite_in,          // ahb write
  input  wire logic [2:0]  hsize_in,           // ahb size
  input  wire logic [31:0] hwdata_in,          // ahb write data
  input  wire logic        hready_in,          // ahb bus ready
  input  wire logic        crystal_clock_out_in, // crystal clock from the generator
  input  wire logic        stop_mode_in,       // core is in stop
  input  wire logic        wait_mode_in,       // core is in wait
  output logic [31:0]      hrdata_out,         // ahb read data
  output logic             hreadyout_out,      // ahb ready out
  output logic             hresp_out,          // ahb response, always okay
  output logic             irq_out,            // level interrupt request
  output logic             tick_event_flag_out // event flag
);
  // synchronisers for pins
  logic [1:0] xclk_sync_reg, stop_sync_reg, wait_sync_reg;
  logic       xclk_last_reg;
  // control state
  logic       tick_enable_reg, tick_enable_next;
  logic       tick_irq_enable_reg, tick_irq_enable_next;
  logic [2:0] tick_rate_select_reg, tick_rate_select_next;
  logic       predivide_select_reg, predivide_select_next;
  logic       osc_run_in_stop_reg, osc_run_in_stop_next;
  logic       flag_reg, flag_next;
  logic       mask_reg, mask_next;
  logic       irq_reg, irq_next;
  // bus data phase
  logic       dp_wr_reg, dp_wr_next;
  logic       dp_rd_reg, dp_rd_next;
  logic [7:0] dp_addr_reg, dp_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  // misc
  logic        xclk_tick, in_stop, in_wait, chain_run, ovf, ack, closed, addr_ok;
  logic [14:0] count;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      xclk_sync_reg <= 2'h0;
      stop_sync_reg <= 2'h0;
      wait_sync_reg <= 2'h0;
      xclk_last_reg <= 1'b0;
    end else begin
      xclk_sync_reg <= {xclk_sync_reg[0], crystal_clock_out_in};
      stop_sync_reg <= {stop_sync_reg[0], stop_mode_in};
      wait_sync_reg <= {wait_sync_reg[0], wait_mode_in};
      xclk_last_reg <= xclk_sync_reg[1];
    end
  end

  // count source is the crystal clock, seen as rising edges on the system clock [R15]
  assign xclk_tick = xclk_sync_reg[1] & ~xclk_last_reg;
  assign in_stop   = stop_sync_reg[1];
  assign in_wait   = wait_sync_reg[1];
  // stop clears and holds the chain at zero unless the oscillator keeps running; wait does not [R11] [R12] [R13]
  assign chain_run = tick_enable_reg & (~in_stop | osc_run_in_stop_reg);
  // the processor cannot reach the registers in low-power modes [R12] [R13]
  assign closed    = in_stop | in_wait;

  ptu_divider u_div (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .run_in       (chain_run),
    .xclk_tick_in (xclk_tick & ~(in_stop & ~osc_run_in_stop_reg)),
    .prediv_in    (predivide_select_reg),
    .rate_in      (tick_rate_select_reg),
    .ovf_out      (ovf),
    .count_out    (count)
  );

  assign addr_ok = (dp_addr_reg == ptu_pkg::CTRL_OFS) || (dp_addr_reg == ptu_pkg::STATUS_OFS)
                || (dp_addr_reg == ptu_pkg::MASK_OFS) || (dp_addr_reg == ptu_pkg::COUNT_OFS);
  assign ack = dp_wr_reg && !closed && (dp_addr_reg == ptu_pkg::CTRL_OFS)
               && hwdata_in[ptu_pkg::CTRL_ACK_BIT];

  // bus address phase capture; writes land in the data phase
  always_comb begin
    dp_wr_next   = 1'b0;
    dp_rd_next   = 1'b0;
    dp_addr_next = dp_addr_reg;
    if (hsel_in && hready_in && (htrans_in == ptu_pkg::HTRANS_NONSEQ
                                 || htrans_in == ptu_pkg::HTRANS_SEQ)) begin
      dp_wr_next   = hwrite_in;
      dp_rd_next   = ~hwrite_in;
      dp_addr_next = haddr_in[7:0];
    end
  end

  // read data is registered in the address phase so hrdata stands from a flop
  always_comb begin
    rdata_next = ptu_pkg::RESET_WORD;
    if (dp_rd_next && !closed) begin
      unique case (dp_addr_next)
        ptu_pkg::CTRL_OFS: begin
          rdata_next[ptu_pkg::CTRL_EN_BIT]      = tick_enable_reg;
          rdata_next[ptu_pkg::CTRL_IE_BIT]      = tick_irq_enable_reg;
          rdata_next[ptu_pkg::CTRL_RATE_LSB +: 3] = tick_rate_select_reg;
          rdata_next[ptu_pkg::CTRL_PREDIV_BIT]  = predivide_select_reg;
          rdata_next[ptu_pkg::CTRL_OSCSTOP_BIT] = osc_run_in_stop_reg;
        end
        ptu_pkg::STATUS_OFS: begin
          rdata_next[ptu_pkg::STAT_FLAG_BIT] = flag_reg;
          rdata_next[ptu_pkg::STAT_STOP_BIT] = in_stop;
          rdata_next[ptu_pkg::STAT_WAIT_BIT] = in_wait;
        end
        ptu_pkg::MASK_OFS:  rdata_next[ptu_pkg::STAT_FLAG_BIT] = mask_reg;
        ptu_pkg::COUNT_OFS: rdata_next[ptu_pkg::CHAIN_W-1:0] = count;
        default:            rdata_next = ptu_pkg::RESET_WORD;
      endcase
    end
  end

  // control register writes; ignored while the processor is shut out
  always_comb begin
    tick_enable_next      = tick_enable_reg;
    tick_irq_enable_next  = tick_irq_enable_reg;
    tick_rate_select_next = tick_rate_select_reg;
    predivide_select_next = predivide_select_reg;
    osc_run_in_stop_next  = osc_run_in_stop_reg;
    mask_next             = mask_reg;
    if (dp_wr_reg && !closed) begin
      if (dp_addr_reg == ptu_pkg::CTRL_OFS) begin
        tick_enable_next      = hwdata_in[ptu_pkg::CTRL_EN_BIT];
        tick_irq_enable_next  = hwdata_in[ptu_pkg::CTRL_IE_BIT];
        // changing rate while enabled is software's error; the chain follows at once [R10]
        tick_rate_select_next = hwdata_in[ptu_pkg::CTRL_RATE_LSB +: 3];
        predivide_select_next = hwdata_in[ptu_pkg::CTRL_PREDIV_BIT];
        osc_run_in_stop_next  = hwdata_in[ptu_pkg::CTRL_OSCSTOP_BIT];
      end
      if (dp_addr_reg == ptu_pkg::MASK_OFS) begin
        mask_next = hwdata_in[ptu_pkg::STAT_FLAG_BIT];
      end
    end
  end

  // flag: set wins over acknowledge; status write-one-to-clear also acknowledges
  always_comb begin
    flag_next = flag_reg;
    if (ack || (dp_wr_reg && !closed && dp_addr_reg == ptu_pkg::STATUS_OFS
                && hwdata_in[ptu_pkg::STAT_FLAG_BIT])) begin
      flag_next = 1'b0;                 // [R6]
    end
    if (ovf) begin
      flag_next = 1'b1;                 // [R4] [R16]
    end
    irq_next = flag_next & tick_irq_enable_next & mask_next;  // [R5]
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tick_enable_reg      <= 1'b0;
      tick_irq_enable_reg  <= 1'b0;
      tick_rate_select_reg <= 3'h0;
      predivide_select_reg <= 1'b0;
      osc_run_in_stop_reg  <= 1'b0;
      mask_reg             <= 1'b1;
      flag_reg             <= 1'b0;
      irq_reg              <= 1'b0;
      dp_wr_reg            <= 1'b0;
      dp_rd_reg            <= 1'b0;
      dp_addr_reg          <= 8'h00;
      rdata_reg            <= 32'h0000_0000;
    end else begin
      tick_enable_reg      <= tick_enable_next;
      tick_irq_enable_reg  <= tick_irq_enable_next;
      tick_rate_select_reg <= tick_rate_select_next;
      predivide_select_reg <= predivide_select_next;
      osc_run_in_stop_reg  <= osc_run_in_stop_next;
      mask_reg             <= mask_next;
      flag_reg             <= flag_next;
      irq_reg              <= irq_next;
      dp_wr_reg            <= dp_wr_next;
      dp_rd_reg            <= dp_rd_next;
      dp_addr_reg          <= dp_addr_next;
      rdata_reg            <= rdata_next;
    end
  end

  assign hrdata_out          = rdata_reg;
  assign hreadyout_out       = 1'b1;
  assign hresp_out           = 1'b0;
  assign irq_out             = irq_reg;
  assign tick_event_flag_out = flag_reg;

  // assertions
  sequence s_enable_rise;
    $rose(tick_enable_reg);
  endsequence

  // counting from zero needs several crystal ticks before the first event
  sequence s_quiet_start;
    !ovf [*8];
  endsequence

  property p_flag_on_ovf;
    @(posedge clk_in) disable iff (!rst_b_in) ovf |-> ##1 flag_reg;
  endproperty
  a_flag_on_ovf: assert property (p_flag_on_ovf) else $error("flag missed overflow"); // [R4]

  property p_ack_wins_lost;
    @(posedge clk_in) disable iff (!rst_b_in) (ack && ovf) |=> flag_reg;
  endproperty
  a_ack_wins_lost: assert property (p_ack_wins_lost) else $error("event lost on ack"); // [R16]

  property p_ack_clears;
    @(posedge clk_in) disable iff (!rst_b_in) (ack && !ovf) |=> !flag_reg;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear"); // [R6]

  property p_irq_level;
    @(posedge clk_in) disable iff (!rst_b_in)
      1'b1 |-> irq_reg == (flag_reg && tick_irq_enable_reg && mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised"); // [R5]

  property p_irq_cause;
    @(posedge clk_in) disable iff (!rst_b_in) irq_reg |-> flag_reg && tick_irq_enable_reg;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause"); // [R5]

  property p_held_zero;
    @(posedge clk_in) disable iff (!rst_b_in) !tick_enable_reg |=> count == 15'h0000;
  endproperty
  a_held_zero: assert property (p_held_zero) else $error("count not held"); // [R3]

  property p_stop_frozen;
    @(posedge clk_in) disable iff (!rst_b_in)
      (in_stop && !osc_run_in_stop_reg) |=> !ovf;
  endproperty
  a_stop_frozen: assert property (p_stop_frozen) else $error("ran in stop"); // [R12]

  property p_closed_reads;
    @(posedge clk_in) disable iff (!rst_b_in)
      (dp_rd_next && closed) |=> rdata_reg == 32'h0000_0000;
  endproperty
  a_closed_reads: assert property (p_closed_reads) else $error("read while closed"); // [R13]

  property p_ovf_pulse;
    @(posedge clk_in) disable iff (!rst_b_in) ovf |=> !ovf;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow not a pulse"); // [R1]

  property p_first_quiet;
    @(posedge clk_in) disable iff (!rst_b_in) s_enable_rise |-> s_quiet_start;
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("event too soon after enable"); // [R7]
endmodule

// File: bench/ptu_core_model.sv
// far-side model: clock generator crystal output and the core's low-power levels
// assumes the bench raises mode requests by non-blocking assignment after a clk edge
`timescale 1ns/1ps
module ptu_core_model #(
  parameter int HALF_NS = 30
) (
  input  wire logic clk_in,             // system clock
  input  wire logic stop_req_in,        // core enters stop
  input  wire logic wait_req_in,        // core enters wait
  input  wire logic osc_run_in_stop_in, // crystal kept alive in stop
  output logic      xclk_out,           // crystal clock output
  output logic      stop_mode_out,      // stop level
  output logic      wait_mode_out       // wait level
);
  logic osc = 1'b0;
  // fixed phase against clk so that every period counts out exactly
  initial #3.3 forever #(HALF_NS) osc = ~osc;
  // without the stop option the oscillator halts and the count source stands low
  assign xclk_out = osc & ~(stop_req_in & ~osc_run_in_stop_in);
  assign stop_mode_out = stop_req_in;
  assign wait_mode_out = wait_req_in;
endmodule

// File: bench/periodic_timebase_interrupt_test.sv
// testbench for the periodic tick unit: registers, tap periods, irq, low-power modes
// assumes ptu_top answers with zero wait states and the core model beside it
`timescale 1ns/1ps
module periodic_timebase_interrupt_test;
  localparam int XPER = 6; // crystal period in clk cycles
  logic        clk_in   = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        hsel, hwrite, hready, hresp, irq, flag, xclk, stop_m, wait_m;
  logic        stop_req = 1'b0;
  logic        wait_req = 1'b0;
  logic        osc_stop = 1'b0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [31:0] seed     = 32'h68c4;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cyc         = 0;
  int          t0, t1;

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  ptu_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .crystal_clock_out_in(xclk), .stop_mode_in(stop_m),
    .wait_mode_in(wait_m), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .irq_out(irq), .tick_event_flag_out(flag));

  ptu_core_model i_core (.clk_in(clk_in), .stop_req_in(stop_req), .wait_req_in(wait_req),
    .osc_run_in_stop_in(osc_stop), .xclk_out(xclk), .stop_mode_out(stop_m),
    .wait_mode_out(wait_m));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int ratio(input logic [2:0] code, input logic pd);
    int r;
    r = (code < 3) ? (1 << (15 - 2 * code)) : (1 << (10 - code));
    return pd ? r * 128 : r;
  endfunction

  function automatic logic [31:0] cfg(input logic [2:0] code, input logic pd, input logic os);
    return {22'h0, os, pd, 1'b0, code, 4'h3};
  endfunction

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge clk_in);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ofs};
    hwrite <= wr;
    htrans <= ptu_pkg::HTRANS_NONSEQ;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_flag(input int lim);
    int s;
    s = cyc;
    while (flag !== 1'b1 && cyc - s < lim) @(posedge clk_in);
    t1 = cyc;
  endtask

  // rate is only changed while the unit is disabled
  task automatic period(input logic [2:0] code, input logic pd);
    int per;
    int ts;
    per = ratio(code, pd) * XPER;
    bus(1'b1, ptu_pkg::CTRL_OFS, 32'h0);
    // the last event of the previous run is still flagged: clear it first
    bus(1'b1, ptu_pkg::STATUS_OFS, 32'h1);
    rchk(ptu_pkg::COUNT_OFS, 32'h0);
    chk({31'h0, flag}, 32'h0);
    bus(1'b1, ptu_pkg::CTRL_OFS, cfg(code, pd, 1'b0));
    t0 = cyc;
    wait_flag(per + 40);
    chk(32'(t1 - t0 < per * 3 / 4 + 8), 32'h1);
    ts = t1;
    bus(1'b1, ptu_pkg::CTRL_OFS, cfg(code, pd, 1'b0) | 32'h4);
    @(posedge clk_in);
    chk({31'h0, flag}, 32'h0);
    wait_flag(per + 40);
    chk(32'(t1 - ts), 32'(per));
    @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
  endtask

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rchk(ptu_pkg::CTRL_OFS, ptu_pkg::RESET_WORD);
    rchk(ptu_pkg::STATUS_OFS, 32'h0);
    rchk(ptu_pkg::MASK_OFS, 32'h1);
    rchk(ptu_pkg::COUNT_OFS, 32'h0);
    rchk(8'h10, 32'h0);
    repeat (4) begin
      v = rnd();
      bus(1'b1, ptu_pkg::MASK_OFS, v);
      rchk(ptu_pkg::MASK_OFS, {31'h0, v[0]});
    end
    bus(1'b1, ptu_pkg::MASK_OFS, 32'h1);
    for (int c = 7; c >= 2; c--) begin
      period(3'(c), 1'b0);
    end
    period(3'h7, 1'b1);
    // masking gates the request while the flag stays up
    bus(1'b1, ptu_pkg::MASK_OFS, 32'h0);
    repeat (2) @(posedge clk_in);
    chk({30'h0, flag, irq}, 32'h2);
    bus(1'b1, ptu_pkg::MASK_OFS, 32'h1);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, ptu_pkg::STATUS_OFS, 32'h1);
    repeat (2) @(posedge clk_in);
    chk({30'h0, flag, irq}, 32'h0);
    // stop with the oscillator kept alive
    bus(1'b1, ptu_pkg::CTRL_OFS, 32'h0);
    osc_stop <= 1'b1;
    bus(1'b1, ptu_pkg::CTRL_OFS, cfg(3'h7, 1'b0, 1'b1));
    wait_flag(200);
    bus(1'b1, ptu_pkg::CTRL_OFS, cfg(3'h7, 1'b0, 1'b1) | 32'h4);
    stop_req <= 1'b1;
    repeat (3) @(posedge clk_in);
    rchk(ptu_pkg::CTRL_OFS, 32'h0);
    wait_flag(200);
    bus(1'b1, ptu_pkg::STATUS_OFS, 32'h1);
    @(posedge clk_in);
    chk({31'h0, flag}, 32'h1);
    // stop with the oscillator halted: no events
    stop_req <= 1'b0;
    repeat (3) @(posedge clk_in);
    bus(1'b1, ptu_pkg::STATUS_OFS, 32'h1);
    @(posedge clk_in);
    wait_flag(200);
    osc_stop <= 1'b0;
    bus(1'b1, ptu_pkg::CTRL_OFS, cfg(3'h7, 1'b0, 1'b0) | 32'h4);
    stop_req <= 1'b1;
    repeat (300) @(posedge clk_in);
    chk({31'h0, flag}, 32'h0);
    stop_req <= 1'b0;
    repeat (3) @(posedge clk_in);
    // wait mode: registers closed, counting goes on
    wait_req <= 1'b1;
    repeat (3) @(posedge clk_in);
    rchk(ptu_pkg::CTRL_OFS, 32'h0);
    wait_flag(200);
    chk({31'h0, flag}, 32'h1);
    wait_req <= 1'b0;
    repeat (3) @(posedge clk_in);
    bus(1'b1, ptu_pkg::CTRL_OFS, 32'h0);
    end_of_test();
  end

  initial begin
    #900000;
    miscompares++;
    end_of_test();
  end
endmodule
